// [hw/rtcsa_pkg.sv]
// Package for the seconds counter and alarm register block
// Summary of operation
// - 32-bit seconds count as two 16-bit halves
// - Count advances by one each second
// - Tamper counter takes random value on time write
// - Alarm upper half is software writable
// - Alarm lower half is software writable
// - Valid flag set once time written
`default_nettype none
package rtcsa_pkg;
  // Printed offsets are register indices; byte address is four times
  localparam logic [15:0] IDX_TAMPER = 16'h4020;
  localparam logic [15:0] IDX_SEC_HI = 16'h4021;
  localparam logic [15:0] IDX_SEC_LO = 16'h4022;
  localparam logic [15:0] IDX_ALM_HI = 16'h4023;
  localparam logic [15:0] IDX_ALM_LO = 16'h4024;
  localparam logic [15:0] IDX_CTRL = 16'h4025;
  localparam int VALID_BIT = 15;
  localparam int BUSY_BIT = 14;
  localparam int ALM_EN_BIT = 10;
  localparam logic [15:0] RESET_HALF = 16'h0000;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_HZ = 1;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int BUSY_CYCLES = 2;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } rtcsa_word_type;
endpackage
`default_nettype wire

// [hw/rtcsa_regs.sv]
// Seconds counter, alarm and tamper counter behind an APB slave
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rtcsa_regs #(
  parameter int TICK_CYCLES = rtcsa_pkg::TICK_CYCLES
)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic alarmEvent,
  output logic timeValid
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rtcsa_pkg::rtcsa_word_type sec_q, sec_d, alm_q, alm_d;
  logic [15:0] tamper_q, tamper_d, lfsr_q, lfsr_d;
  logic [31:0] tick_q, tick_d;
  logic valid_q, valid_d, almEn_q, almEn_d, alarm_q, alarm_d;
  logic [1:0] busy_q, busy_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d, err_q, err_d;
  logic access, wrAcc, hit;
  logic [15:0] idx;
  logic [15:0] rdHalf;
  logic [31:0] secNext;

  assign access = psel & penable & ~ready_q;
  assign wrAcc = access & pwrite;
  assign idx = paddr[17:2];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    sec_d = sec_q;
    alm_d = alm_q;
    tamper_d = tamper_q;
    valid_d = valid_q;
    almEn_d = almEn_q;
    busy_d = (busy_q != 2'h0) ? busy_q - 2'h1 : 2'h0;
    // Free running, so each seconds write draws a fresh pseudo random value
    lfsr_d = {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? rtcsa_pkg::LFSR_TAPS :
      16'h0000);
    tick_d = (tick_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_q + 32'h1;
    secNext = sec_q + 32'h1;
    if (tick_q == 32'(TICK_CYCLES - 1))
      sec_d = secNext;
    hit = 1'b1;
    unique case (idx)
      rtcsa_pkg::IDX_TAMPER: rdHalf = tamper_q;
      rtcsa_pkg::IDX_SEC_HI: rdHalf = sec_q.high;
      rtcsa_pkg::IDX_SEC_LO: rdHalf = sec_q.low;
      rtcsa_pkg::IDX_ALM_HI: rdHalf = alm_q.high;
      rtcsa_pkg::IDX_ALM_LO: rdHalf = alm_q.low;
      rtcsa_pkg::IDX_CTRL:
        rdHalf = 16'(({15'h0, valid_q} << rtcsa_pkg::VALID_BIT)
          | ({15'h0, busy_q != 2'h0} << rtcsa_pkg::BUSY_BIT)
          | ({15'h0, almEn_q} << rtcsa_pkg::ALM_EN_BIT));
      default:
      begin
        rdHalf = 16'h0000;
        hit = 1'b0;
      end
    endcase
    if (paddr[1:0] != 2'h0 || paddr[31:18] != 14'h0)
      hit = 1'b0;
    // Writes during busy are software's fault; they still land
    if (wrAcc && hit)
    begin
      unique case (idx)
        rtcsa_pkg::IDX_SEC_HI:
        begin
          sec_d.high = pwdata[15:0];
          tamper_d = lfsr_q;
          valid_d = 1'b1;
          busy_d = 2'(rtcsa_pkg::BUSY_CYCLES);
        end
        rtcsa_pkg::IDX_SEC_LO:
        begin
          sec_d.low = pwdata[15:0];
          tamper_d = lfsr_q;
          valid_d = 1'b1;
          busy_d = 2'(rtcsa_pkg::BUSY_CYCLES);
        end
        rtcsa_pkg::IDX_ALM_HI: alm_d.high = pwdata[15:0];
        rtcsa_pkg::IDX_ALM_LO: alm_d.low = pwdata[15:0];
        rtcsa_pkg::IDX_CTRL:
          almEn_d = pwdata[rtcsa_pkg::ALM_EN_BIT];
        default: ;
      endcase
    end
    // Edge of equality only, so a matching second fires once
    alarm_d = almEn_q && (sec_d == alm_q) && (sec_q != alm_q);
    ready_d = access;
    err_d = access & ~hit;
    rdata_d = (access && !pwrite && hit) ? {16'h0000, rdHalf} : 32'h0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sec_q <= '0;
      alm_q <= '0;
      tamper_q <= rtcsa_pkg::RESET_HALF;
      lfsr_q <= rtcsa_pkg::LFSR_SEED;
      tick_q <= 32'h0;
      valid_q <= 1'b0;
      almEn_q <= 1'b0;
      alarm_q <= 1'b0;
      busy_q <= 2'h0;
      rdata_q <= 32'h0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      sec_q <= sec_d;
      alm_q <= alm_d;
      tamper_q <= tamper_d;
      lfsr_q <= lfsr_d;
      tick_q <= tick_d;
      valid_q <= valid_d;
      almEn_q <= almEn_d;
      alarm_q <= alarm_d;
      busy_q <= busy_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  assign alarmEvent = alarm_q;
  assign timeValid = valid_q;
endmodule
`default_nettype wire

// [verification/rtcsa_monitor.sv]
// Assertions on the seconds and alarm register block
`timescale 1ns/1ps
`default_nettype none
module rtcsa_monitor #(parameter int TICK_CYCLES = 10)(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alarmEvent,
  input wire logic timeValid
);
  // ------
  // Checks
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic acc = psel && penable && !pready;
  AST_RDY: assert property (acc |=> pready) else $error("no ready");
  AST_PULSE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERR: assert property (pslverr |-> pready) else $error("lone error");
  AST_IDLE: assert property (!pready |-> prdata == 0) else $error("stale");
  AST_MIS: assert property (acc && paddr[1:0] != 0 |=> pslverr)
    else $error("misaligned accepted");
  AST_ALM: assert property (alarmEvent |=> !alarmEvent)
    else $error("alarm held");
  AST_VHOLD: assert property (timeValid |=> timeValid)
    else $error("valid lost");
  AST_VSET: assert property (acc && pwrite && paddr == 32'h0001_0084
    |=> ##1 timeValid) else $error("valid not set");
  cover property (pslverr);
  cover property (alarmEvent);
  cover property (acc && pwrite);
endmodule
bind rtcsa_regs rtcsa_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.*);
`default_nettype wire

// [verification/test_rtc_seconds_alarm_regs.sv]
// Self-checking bench for the seconds and alarm register block
`timescale 1ns/1ps
`default_nettype none
module test_rtc_seconds_alarm_regs;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd, t0, rnd = 32'h0001_3CD7;
  logic pready, pslverr, alarmEvent, timeValid, er;
  int error_cnt = 0, n_tests = 0;
  // Short tick keeps carry and alarm within a few hundred cycles
  rtcsa_regs #(.TICK_CYCLES(10)) u_dut (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .alarmEvent(alarmEvent), .timeValid(timeValid));
  initial forever #5 clk = ~clk;
  // ---------------
  // Tasks and flow
  // ---------------
  // Fixed seed keeps every run repeatable
  function logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function logic [31:0] ad(input logic [15:0] i);
    return {14'h0000, i, 2'h0};
  endfunction
  task conclude;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task hang;
    error_cnt++;
    conclude();
  endtask
  task chk(input string nm, input logic [31:0] s, x);
    n_tests++;
    if (s !== x)
    begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, x, s);
    end
  endtask
  // Leading edge wait avoids two strobe updates in one step
  task apb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) hang();
  endtask
  task idle;
    for (int i = 0; i < 9; i++)
    begin
      apb(0, ad(rtcsa_pkg::IDX_CTRL), 0);
      if (rd[rtcsa_pkg::BUSY_BIT] === 1'b0) return;
    end
    hang();
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    for (int k = 0; k < 6; k++)
    begin
      if (k == 2) continue;
      apb(0, ad(16'(rtcsa_pkg::IDX_TAMPER + k)), 0);
      chk("reset", rd, 0);
    end
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      apb(1, ad(rtcsa_pkg::IDX_ALM_HI + k[0]), rnd);
      apb(0, ad(rtcsa_pkg::IDX_ALM_HI + k[0]), 0);
      chk("alarm", rd, {16'h0000, rnd[15:0]});
    end
    apb(0, ad(16'h4026), 0);
    chk("unmapped", er, 1);
    apb(1, ad(rtcsa_pkg::IDX_ALM_HI) + 32'h1, 0);
    chk("misaligned", er, 1);
    apb(0, ad(rtcsa_pkg::IDX_TAMPER), 0);
    t0 = rd;
    idle();
    apb(1, ad(rtcsa_pkg::IDX_SEC_HI), {16'h0000, rnd[31:16]});
    idle();
    apb(1, ad(rtcsa_pkg::IDX_SEC_LO), 32'h0000_FFFF);
    chk("valid", timeValid, 1);
    apb(0, ad(rtcsa_pkg::IDX_TAMPER), 0);
    chk("tamper", rd != t0, 1);
    t0 = rd;
    apb(1, ad(rtcsa_pkg::IDX_TAMPER), 32'h0000_1234);
    apb(0, ad(rtcsa_pkg::IDX_TAMPER), 0);
    chk("tamper ro", rd, t0);
    repeat (20) @(posedge clk);
    apb(0, ad(rtcsa_pkg::IDX_SEC_HI), 0);
    chk("carry", rd, {16'h0000, rnd[31:16] + 16'h1});
    apb(1, ad(rtcsa_pkg::IDX_ALM_HI), {16'h0000, rnd[31:16] + 16'h1});
    apb(1, ad(rtcsa_pkg::IDX_ALM_LO), 32'h0000_0008);
    apb(1, ad(rtcsa_pkg::IDX_CTRL), 32'h0000_0400);
    for (int i = 0; i < 200 && alarmEvent !== 1'b1; i++) @(posedge clk);
    if (alarmEvent !== 1'b1) hang();
    apb(0, ad(rtcsa_pkg::IDX_SEC_LO), 0);
    chk("alarm hit", rd, 32'h0000_0008);
    conclude();
  end
endmodule
`default_nettype wire
